// ---- dv/eerp_bfm.sv ----
/* bus master model: serial clock and open-drain data.
   assumes a pulled-up data wire in the bench. */
`timescale 1ns/10ps
module eerp_bfm (
   // clock
   input  wire CLK,
   // serial bus
   input  wire sda,
   output reg  scl = 1'b1,
   output reg  m_oe = 1'b0
);
   task hold(input integer n);
      repeat (n) @(negedge CLK);
   endtask
   // waits let the target let go first
   task start;
      m_oe = 0;
      hold(6);
      scl = 1;
      hold(8);
      m_oe = 1;
      hold(8);
      scl = 0;
   endtask
   task stop;
      m_oe = 1;
      hold(6);
      scl = 1;
      hold(8);
      m_oe = 0;
      hold(8);
   endtask
   // nine bits: byte msb first, then ack slot
   task xfer(input [8:0] d, output reg [8:0] q);
      integer i;
      for (i = 8; i >= 0; i--) begin
         hold(2);
         m_oe = !d[i];
         hold(6);
         scl = 1;
         hold(4);
         q[i] = sda;
         hold(4);
         scl = 0;
      end
   endtask
endmodule // eerp_bfm

// ---- dv/eerp_target_bench.sv ----
/* bench for eerp_target: writes, reads, protect.
   assumes eerp_bfm and the bound checker. */
`timescale 1ns/10ps
`include "eerp_defines.vh"
module eerp_target_bench;
   reg        CLK = 0, RST_B = 0, WP_I = 0;
   wire       scl, m_oe, SDA_O, SDA_OE, BUSY;
   wire       sda = !(m_oe | SDA_OE);
   integer    fails = 0, checks_done = 0, cyc = 0, k;
   reg  [7:0] mem [0:255];
   reg  [7:0] a;
   reg  [8:0] q;
   localparam [7:0] W = {`EERP_TYPE_PREFIX, 4'h0};
   localparam [7:0] R = W | 8'h01;
   function [7:0] nxt(input [7:0] n);
      nxt = n + 8'h01;
   endfunction
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin fails++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
   eerp_target i_eerp_target (.CLK(CLK), .RST_B(RST_B), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(SDA_O), .SDA_OE(SDA_OE), .WP_I(WP_I), .BUSY(BUSY));
   eerp_bfm i_eerp_bfm (.CLK(CLK), .sda(sda), .scl(scl), .m_oe(m_oe));
   initial forever #5 CLK = !CLK;
   task end_sim;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         end_sim;
      end
   end
   task send(input [7:0] b, input e);
      i_eerp_bfm.xfer({b, 1'b1}, q);
      `CHK("ack", e, !q[0])
   endtask
   task get(input [7:0] x, input last);
      i_eerp_bfm.xfer({8'hff, last}, q);
      `CHK("data", mem[x], q[8:1])
   endtask
   task op(input [7:0] h);
      i_eerp_bfm.start;
      send(h, 1);
   endtask
   initial begin
      k = $urandom(68969);
      repeat (2) @(negedge CLK);
      RST_B = 1;
      repeat (6) @(negedge CLK);
      // descending writes leave the counter at 254
      for (k = 0; k < 6; k++) begin
         a = 8'(2 - k);
         mem[a] = 8'($urandom);
         op(W);
         send(a, 1);
         send(mem[a], 1);
         i_eerp_bfm.stop;
      end
      op(R);
      get(nxt(a), 1);
      i_eerp_bfm.stop;
      op(R);
      get(255, 0);
      get(nxt(8'hff), 0);
      get(1, 1);
      i_eerp_bfm.stop;
      WP_I = 1;
      op(W);
      send(253, 1);
      send(~mem[253], 0);
      send(8'h00, 0);
      i_eerp_bfm.stop;
      op(W);
      send(253, 1);
      op(R);
      get(253, 0);
      get(254, 1);
      i_eerp_bfm.stop;
      i_eerp_bfm.start;
      send(W ^ 8'h80, 0);
      i_eerp_bfm.stop;
      end_sim;
   end
endmodule // eerp_target_bench

// ---- dv/eerp_target_properties.sv ----
/* port checker for eerp_target.
   assumes bind to every eerp_target. */
`timescale 1ns/10ps
module eerp_target_properties (
   // clock and reset
   input wire CLK,
   input wire RST_B,
   // pins
   input wire SCL_I,
   input wire SDA_I,
   input wire SDA_O,
   input wire SDA_OE,
   input wire WP_I,
   input wire BUSY
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   sequence s_start; SCL_I && $fell(SDA_I); endsequence
   sequence s_stop; SCL_I && $rose(SDA_I); endsequence
   a_drive_zero: assert property (SDA_OE |-> !SDA_O)
      else $error("drive not low");
   a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_I)
      else $error("drive moved, clock high");
   a_oe_after_fall: assert property ($rose(SDA_OE) |-> $past(SCL_I, 6))
      else $error("drive late");
   a_idle_release: assert property (!BUSY |-> !SDA_OE)
      else $error("drive while idle");
   a_busy_start: assert property (s_start |-> ##[1:6] BUSY)
      else $error("start missed");
   a_busy_stop: assert property (s_stop |-> ##[1:6] !BUSY)
      else $error("stop missed");
   a_busy_rise: assert property ($rose(BUSY) |-> SCL_I)
      else $error("busy without start");
   a_busy_fall: assert property ($fell(BUSY) |-> SCL_I && SDA_I)
      else $error("busy ended without stop");
endmodule // eerp_target_properties
bind eerp_target eerp_target_properties i_props (.CLK(CLK), .RST_B(RST_B), .SCL_I(SCL_I),
   .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .WP_I(WP_I), .BUSY(BUSY));

// ---- src/eerp_defines.vh ----
/*
 constants for the serial eeprom read and write-protect target.
 assumes inclusion by bare name from the design files.
*/
`ifndef EERP_DEFINES_VH
`define EERP_DEFINES_VH
// target address prefix, upper four bits (arbitrary value)
`define EERP_TYPE_PREFIX    4'h5
`define EERP_RW_BIT         0
`define EERP_ADDR_RESET     8'h00
`define EERP_BITS_PER_BYTE  4'h8
`define EERP_ACK_SLOT       4'h8
`define EERP_MEM_WORDS      256
`endif

// ---- src/eerp_sync.v ----
/*
 two flip-flop synchroniser for the serial clock, data and protect pins.
 assumes asynchronous pins and an active low asynchronous reset.
*/
`timescale 1ns/10ps
module eerp_sync #(
   parameter WIDTH = 3
) (
   // clock and reset
   input  wire             clk,
   input  wire             rst_b,
   // pins
   input  wire [WIDTH-1:0] d,
   output reg  [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta;
   // idle bus level is high, so reset to ones
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= {WIDTH{1'b1}};
         q    <= {WIDTH{1'b1}};
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // eerp_sync

// ---- src/eerp_target.v ----
/*
 target side of a 256-byte serial eeprom: reads, address counter, write protect.
 assumes scl and sda come from a bus master outside the clock domain, sda open-drain.
*/
`timescale 1ns/10ps
`include "eerp_defines.vh"
module eerp_target #(
   parameter DEPTH = `EERP_MEM_WORDS,
   parameter AW    = 8
) (
   // clock and reset
   input  wire CLK,
   input  wire RST_B,
   // serial bus
   input  wire SCL_I,
   input  wire SDA_I,
   output reg  SDA_O,
   output reg  SDA_OE,
   // write protect pin
   input  wire WP_I,
   // status
   output reg  BUSY
);
   localparam ST_IDLE = 3'h0;
   localparam ST_DEV  = 3'h1;
   localparam ST_ADDR = 3'h2;
   localparam ST_WDAT = 3'h3;
   localparam ST_RDAT = 3'h4;
   localparam ST_WAIT = 3'h5;

   wire [2:0]    pins;
   reg           scl_d;
   reg           sda_d;
   reg  [2:0]    state;
   reg  [3:0]    bitcnt;
   reg  [7:0]    shreg;
   reg  [AW-1:0] addr;
   reg           ack_phase;
   reg           ack_ok;
   // whole array kept here; no programming delay is modelled
   reg  [7:0]    mem [0:DEPTH-1];

   eerp_sync #(.WIDTH(3)) u_sync (
      .clk   (CLK),
      .rst_b (RST_B),
      .d     ({WP_I, SDA_I, SCL_I}),
      .q     (pins)
   );

   // pins arrive two clocks late, so the bus must run well below CLK
   wire scl  = pins[0];
   wire sda  = pins[1];
   wire wp   = pins[2];
   wire rise = scl & ~scl_d;
   wire fall = ~scl & scl_d;
   wire start_c = scl & scl_d & sda_d & ~sda;
   wire stop_c  = scl & scl_d & ~sda_d & sda;

   function dev_match;
      input [7:0] b;
      dev_match = (b[7:4] == `EERP_TYPE_PREFIX);
   endfunction

   // full-width increment: wraps 255 to 0 and crosses every page
   function [AW-1:0] addr_inc;
      input [AW-1:0] a;
      addr_inc = a + {{(AW-1){1'b0}}, 1'b1};
   endfunction

   // whether the byte just taken earns an acknowledge
   always @* begin
      ack_ok = 1'b0;
      case (state)
         ST_DEV: begin
            ack_ok = dev_match(shreg);
         end
         ST_ADDR: begin
            ack_ok = 1'b1;
         end
         ST_WDAT: begin
            ack_ok = ~wp;
         end
         default: begin
            ack_ok = 1'b0;
         end
      endcase
   end

   // previous pin samples for edge and start/stop detection
   always @(posedge CLK or negedge RST_B) begin
      // reset to the idle level so no false edge follows reset
      if (!RST_B) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end

   // bus held from start to stop; a repeated start keeps it high
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         BUSY <= 1'b0;
      end else if (start_c) begin
         BUSY <= 1'b1;
      end else if (stop_c) begin
         BUSY <= 1'b0;
      end
   end

   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state     <= ST_IDLE;
         bitcnt    <= 4'h0;
         shreg     <= 8'h00;
         addr      <= `EERP_ADDR_RESET;
         ack_phase <= 1'b0;
         SDA_O     <= 1'b0;  // open drain: the pin is only ever pulled low
         SDA_OE    <= 1'b0;
      end else begin
         // start and stop take priority over any bit edge
         if (start_c) begin
            // repeated start allowed mid-transfer
            state     <= ST_DEV;
            bitcnt    <= 4'h0;
            ack_phase <= 1'b0;
            SDA_OE    <= 1'b0;
         end else if (stop_c) begin
            state  <= ST_IDLE;
            SDA_OE <= 1'b0;
         end else if (rise && !ack_phase && state != ST_IDLE && state != ST_WAIT) begin
            shreg  <= {shreg[6:0], sda};
            bitcnt <= bitcnt + 4'h1;
         end else if (rise && ack_phase && state == ST_RDAT) begin
            if (sda) begin
               state <= ST_WAIT;
            end
         end else if (fall) begin
            if (ack_phase) begin
               // ninth clock done
               ack_phase <= 1'b0;
               bitcnt    <= 4'h0;
               SDA_OE    <= 1'b0;
               if (state == ST_RDAT) begin
                  // next byte per master ack
                  SDA_OE <= ~mem[addr][7];
                  shreg  <= mem[addr];
                  addr   <= addr_inc(addr);
               end
            end else if (state == ST_RDAT && bitcnt != `EERP_BITS_PER_BYTE) begin
               // each rise shifts left, so the next bit out is always the top one
               SDA_OE <= ~shreg[7];
            end else if (bitcnt == `EERP_ACK_SLOT) begin
               ack_phase <= 1'b1;
               SDA_O     <= 1'b0;
               SDA_OE    <= ack_ok;
               case (state)
                  ST_DEV: begin
                     if (ack_ok) begin
                        if (shreg[`EERP_RW_BIT]) begin
                           state <= ST_RDAT;
                        end else begin
                           state <= ST_ADDR;
                        end
                     end else begin
                        // wrong prefix: stay off the bus until the next start
                        state <= ST_WAIT;
                     end
                  end
                  ST_ADDR: begin
                     addr  <= shreg[AW-1:0];
                     state <= ST_WDAT;
                  end
                  ST_WDAT: begin
                     if (ack_ok) begin
                        // programming is outside this block; counter still advances
                        addr <= addr_inc(addr);
                     end else begin
                        // refused byte is dropped, array untouched
                        state <= ST_WAIT;
                     end
                  end
                  ST_RDAT: begin
                     // ack_ok is low here: line released for the master ack
                     state <= ST_RDAT;
                  end
                  default: begin
                     state <= ST_WAIT;
                  end
               endcase
            end
         end
      end
   end

   // write data path; an accepted byte is stored at the fall that opens its ack slot
   always @(posedge CLK) begin
      if (fall && !ack_phase && bitcnt == `EERP_ACK_SLOT && state == ST_WDAT && ack_ok) begin
         mem[addr] <= shreg;
      end
   end
endmodule // eerp_target
